// [fpec_defs.vh]
/*
 * constants for the flash program/erase control block: register offsets,
 * field positions, reset values and array geometry.
 * assumes inclusion by bare name from the design file; definitions only.
 */
// How it works
// - each program run streams exactly 128 bytes, never fewer or more
// - array is four 1-kbyte erase blocks then one 28-kbyte block
// - one erase touches one block; whole array means erasing each block
// - write-enable bit 6 permits program and erase; resets to zero
// - with write-enable clear, other control and block-select bits stay zero
// - bit 5 enters erase setup when set, leaves it when cleared
// - bit 4 enters program setup when set, leaves it when cleared
// - bit 3 set enters erase-verify mode, cleared leaves it
// - bit 2 set enters program-verify mode, cleared leaves it
// - bit 1 gives erase mode only with write-enable and erase setup
// - bit 0 gives program mode only with write-enable and program setup
// - bit 7 reserved, reads zero, writes ignored
// - more than one block-select bit written clears all of them
// - top select bit picks 0x1000-0x7FFF; lower bits 1-kbyte blocks ascending
`ifndef FPEC_DEFS_VH
`define FPEC_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define FPEC_OFS_MODE      10'h000
`define FPEC_OFS_STATUS    10'h004
`define FPEC_OFS_BLKSEL    10'h008
`define FPEC_OFS_ACCEN     10'h00C
`define FPEC_OFS_PADDR     10'h010
`define FPEC_BUF_BASE_HI   3'h4

// ****************************************
// field positions
// ****************************************
`define FPEC_BIT_WREN      6
`define FPEC_BIT_ESET      5
`define FPEC_BIT_PSET      4
`define FPEC_BIT_EVFY      3
`define FPEC_BIT_PVFY      2
`define FPEC_BIT_E         1
`define FPEC_BIT_P         0
`define FPEC_BIT_ERR       7
`define FPEC_BIT_BUSY      0
`define FPEC_BIT_ACCEN     7

// ****************************************
// reset values
// ****************************************
// bit 7 is reserved and not stored, so the mode word is seven bits
`define FPEC_RST_MODE      7'h00
`define FPEC_RST_BLKSEL    5'h00
`define FPEC_RST_ACCEN     1'b0

// ****************************************
// array geometry
// ****************************************
`define FPEC_PAGE_BYTES    128
`define FPEC_PAGE_MASK     15'h7F80
`define FPEC_BASE_BLK0     15'h0000
`define FPEC_BASE_BLK1     15'h0400
`define FPEC_BASE_BLK2     15'h0800
`define FPEC_BASE_BLK3     15'h0C00
`define FPEC_BASE_BLK4     15'h1000

`endif

// [fpec_flash_ctrl.v]
/*
 * flash program/erase control: avalon-mm register slave, mode control
 * register, block select, 128-byte page buffer and program/erase sequencer.
 * assumes an avalon-mm master on sys_clk and a flash macro on the same clock
 * that takes one byte per cycle while fl_prog_we is high.
 */
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`include "fpec_defs.vh"

module fpec_flash_ctrl #(
    parameter PAGE_BYTES = `FPEC_PAGE_BYTES
) (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [9:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg         fl_prog_we,
    output reg  [14:0] fl_prog_addr,
    output reg  [7:0]  fl_prog_data,
    output reg         fl_erase_en,
    output reg  [4:0]  fl_erase_blk,
    output reg  [14:0] fl_erase_base,
    output reg         fl_erase_setup,
    output reg         fl_prog_setup,
    output reg         fl_erase_verify,
    output reg         fl_prog_verify
);

// ****************************************
// helpers
// ****************************************
    localparam WORDS = PAGE_BYTES / 4;

    function reg_hit;
        input [9:0] adr;
        input [9:0] ofs;
        begin
            reg_hit = adr == ofs;
        end
    endfunction

    function more_than_one;
        input [4:0] v;
        begin
            more_than_one = (v & (v - 5'h01)) != 5'h00;
        end
    endfunction

    function [14:0] blk_base;
        input [4:0] sel;
        begin
            case (sel)
                5'h01:   blk_base = `FPEC_BASE_BLK0;
                5'h02:   blk_base = `FPEC_BASE_BLK1;
                5'h04:   blk_base = `FPEC_BASE_BLK2;
                5'h08:   blk_base = `FPEC_BASE_BLK3;
                5'h10:   blk_base = `FPEC_BASE_BLK4;
                default: blk_base = `FPEC_BASE_BLK0;
            endcase
        end
    endfunction

// ****************************************
// registers and state
// ****************************************
    localparam ST_IDLE = 2'd0;
    localparam ST_PROG = 2'd1;
    localparam ST_DONE = 2'd2;

    // bit 7 reserved, so only bits 6..0 are kept
    reg  [6:0]  mode_r;
    reg  [6:0]  mode_nxt;
    reg  [4:0]  blksel_r;
    reg  [4:0]  blksel_nxt;
    reg         accen_r;
    reg  [14:0] paddr_r;
    reg         err_r;
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [6:0]  cnt_r;
    reg  [31:0] pbuf [0:WORDS-1];
    reg  [31:0] rd_nxt;
    reg  [31:0] status_word;
    reg  [31:0] accen_word;

    wire        req     = avs_read | avs_write;
    wire        commit  = avs_write & ~avs_waitrequest;
    wire        is_buf  = avs_address[9:7] == `FPEC_BUF_BASE_HI;
    wire [4:0]  buf_idx = avs_address[6:2];
    wire        wr_mode = commit & accen_r & reg_hit(avs_address, `FPEC_OFS_MODE);
    wire        wr_blk  = commit & accen_r & reg_hit(avs_address, `FPEC_OFS_BLKSEL);
    wire        wr_acc  = commit & reg_hit(avs_address, `FPEC_OFS_ACCEN);
    wire        wr_pad  = commit & reg_hit(avs_address, `FPEC_OFS_PADDR);
    wire        wr_buf  = commit & is_buf;

    wire        wen  = mode_r[`FPEC_BIT_WREN];
    wire        eset = mode_r[`FPEC_BIT_ESET];
    wire        pset = mode_r[`FPEC_BIT_PSET];
    wire        e_q  = mode_r[`FPEC_BIT_E];
    wire        p_q  = mode_r[`FPEC_BIT_P];
    wire        clash = e_q & p_q;

    wire        erase_mode = e_q & wen & eset & ~clash;
    wire        prog_mode  = p_q & wen & pset & ~clash;
    // done counts as busy, so erase waits until program mode drops
    wire        busy       = state_r != ST_IDLE;

// ****************************************
// bus handshake
// ****************************************
    // one wait cycle, then the request completes; read data stand at that edge
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= rd_nxt;
            end
        end
    end

    always @* begin
        status_word = 32'h0000_0000;
        accen_word  = 32'h0000_0000;
        status_word[`FPEC_BIT_ERR]  = err_r;
        status_word[`FPEC_BIT_BUSY] = busy;
        accen_word[`FPEC_BIT_ACCEN] = accen_r;
    end

    // control words read zero while register access is off
    always @* begin
        rd_nxt = 32'h0000_0000;
        if (is_buf) begin
            rd_nxt = pbuf[buf_idx];
        end else begin
            case (avs_address)
                `FPEC_OFS_MODE: begin
                    if (accen_r) begin
                        rd_nxt = {25'h000_0000, mode_r};
                    end
                end
                `FPEC_OFS_STATUS: begin
                    if (accen_r) begin
                        rd_nxt = status_word;
                    end
                end
                `FPEC_OFS_BLKSEL: begin
                    if (accen_r) begin
                        rd_nxt = {27'h000_0000, blksel_r};
                    end
                end
                `FPEC_OFS_ACCEN:  rd_nxt = accen_word;
                `FPEC_OFS_PADDR:  rd_nxt = {17'h0_0000, paddr_r};
                default:          rd_nxt = 32'h0000_0000;
            endcase
        end
    end

// ****************************************
// control register
// ****************************************
    always @* begin
        mode_nxt = mode_r;
        if (wr_mode & avs_byteenable[0]) begin
            mode_nxt[`FPEC_BIT_WREN] = avs_writedata[`FPEC_BIT_WREN];
            // other bits need write-enable already set
            if (avs_writedata[`FPEC_BIT_WREN] & wen) begin
                mode_nxt[`FPEC_BIT_ESET] = avs_writedata[`FPEC_BIT_ESET];
                mode_nxt[`FPEC_BIT_PSET] = avs_writedata[`FPEC_BIT_PSET];
                mode_nxt[`FPEC_BIT_EVFY] = avs_writedata[`FPEC_BIT_EVFY];
                mode_nxt[`FPEC_BIT_PVFY] = avs_writedata[`FPEC_BIT_PVFY];
                mode_nxt[`FPEC_BIT_E]   = avs_writedata[`FPEC_BIT_E];
                mode_nxt[`FPEC_BIT_P]   = avs_writedata[`FPEC_BIT_P];
            end else begin
                mode_nxt[5:0] = 6'h00;
            end
        end
    end

    always @* begin
        blksel_nxt = blksel_r;
        if (wr_blk & avs_byteenable[0]) begin
            // several bits at once clear all
            if (more_than_one(avs_writedata[4:0])) begin
                blksel_nxt = 5'h00;
            end else begin
                blksel_nxt = avs_writedata[4:0];
            end
        end
        if (!mode_nxt[`FPEC_BIT_WREN]) begin
            blksel_nxt = 5'h00;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r   <= `FPEC_RST_MODE;
            blksel_r <= `FPEC_RST_BLKSEL;
            accen_r  <= `FPEC_RST_ACCEN;
            paddr_r  <= 15'h0000;
        end else begin
            mode_r   <= mode_nxt;
            blksel_r <= blksel_nxt;
            if (wr_acc & avs_byteenable[0]) begin
                accen_r <= avs_writedata[`FPEC_BIT_ACCEN];
            end
            // low seven bits dropped so a page never straddles
            if (wr_pad & (avs_byteenable[1:0] == 2'b11)) begin
                paddr_r <= avs_writedata[14:0] & `FPEC_PAGE_MASK;
            end
        end
    end

    // error sticks until reset
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_r <= 1'b0;
        end else if (clash & wen) begin
            err_r <= 1'b1;
        end
    end

// ****************************************
// page buffer
// ****************************************
    // no reset on the array; contents are defined by software before use
    always @(posedge sys_clk) begin
        if (wr_buf) begin
            if (avs_byteenable[0]) pbuf[buf_idx][7:0]   <= avs_writedata[7:0];
            if (avs_byteenable[1]) pbuf[buf_idx][15:8]  <= avs_writedata[15:8];
            if (avs_byteenable[2]) pbuf[buf_idx][23:16] <= avs_writedata[23:16];
            if (avs_byteenable[3]) pbuf[buf_idx][31:24] <= avs_writedata[31:24];
        end
    end

    wire [31:0] cur_word = pbuf[cnt_r[6:2]];
    reg  [7:0]  cur_byte;

    always @* begin
        case (cnt_r[1:0])
            2'd0:    cur_byte = cur_word[7:0];
            2'd1:    cur_byte = cur_word[15:8];
            2'd2:    cur_byte = cur_word[23:16];
            default: cur_byte = cur_word[31:24];
        endcase
    end

// ****************************************
// program sequencer
// ****************************************
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (prog_mode) begin
                    state_nxt = ST_PROG;
                end
            end
            ST_PROG: begin
                // run ends after the last of 128 bytes
                if (cnt_r == PAGE_BYTES - 1) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                // one run per entry into program mode
                if (!prog_mode) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r      <= ST_IDLE;
            cnt_r        <= 7'h00;
            fl_prog_we   <= 1'b0;
            fl_prog_addr <= 15'h0000;
            fl_prog_data <= 8'h00;
        end else begin
            state_r <= state_nxt;
            // a started page always completes in full
            if (state_r == ST_PROG) begin
                fl_prog_we   <= 1'b1;
                fl_prog_addr <= paddr_r | {8'h00, cnt_r};
                fl_prog_data <= cur_byte;
                cnt_r        <= cnt_r + 7'h01;
            end else begin
                fl_prog_we <= 1'b0;
                cnt_r      <= 7'h00;
            end
        end
    end

// ****************************************
// erase and mode outputs
// ****************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fl_erase_en     <= 1'b0;
            fl_erase_blk    <= 5'h00;
            fl_erase_base   <= 15'h0000;
            fl_erase_setup  <= 1'b0;
            fl_prog_setup   <= 1'b0;
            fl_erase_verify <= 1'b0;
            fl_prog_verify  <= 1'b0;
        end else begin
            // exactly one block per erase; none selected, no erase
            fl_erase_en     <= erase_mode & (blksel_r != 5'h00) & ~busy;
            fl_erase_blk    <= blksel_r;
            // four small blocks then the large one
            fl_erase_base   <= blk_base(blksel_r);
            fl_erase_setup  <= wen & eset;
            fl_prog_setup   <= wen & pset;
            fl_erase_verify <= wen & mode_r[`FPEC_BIT_EVFY];
            fl_prog_verify  <= wen & mode_r[`FPEC_BIT_PVFY];
        end
    end

endmodule // fpec_flash_ctrl

// [fpec_flash_ctrl_assertions.sv]
/* port checker for fpec_flash_ctrl.
   assumes bind onto the design top, one clock, async active-low reset. */
`timescale 1ns/10ps
module fpec_chk (
    input wire        sys_clk,
    input wire        rst_n,
    input wire [9:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        fl_prog_we,
    input wire [14:0] fl_prog_addr,
    input wire [7:0]  fl_prog_data,
    input wire        fl_erase_en,
    input wire [4:0]  fl_erase_blk,
    input wire [14:0] fl_erase_base,
    input wire        fl_erase_setup,
    input wire        fl_prog_setup,
    input wire        fl_erase_verify,
    input wire        fl_prog_verify
);
    // ****************************************
    // helpers and properties
    // ****************************************
    // run length kept in a counter: a 128 repetition would unroll badly
    reg  [8:0]  run_r;
    wire [14:0] exp_base = fl_erase_blk[4] ? 15'h1000 : fl_erase_blk[3] ? 15'h0C00 :
                           fl_erase_blk[2] ? 15'h0800 : fl_erase_blk[1] ? 15'h0400 : 15'h0000;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            run_r <= 9'h000;
        else
            run_r <= fl_prog_we ? run_r + 9'h001 : 9'h000;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    AST_ANSWER: assert property (s_req |=> s_ans)
        else $error("bus answer not one cycle");
    AST_NO_SPURIOUS: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("waitrequest dropped without request");
    AST_PAGE_LEN: assert property ($fell(fl_prog_we) |-> run_r == 9'h080)
        else $error("page run not 128 bytes");
    AST_RUN_MAX: assert property (run_r <= 9'h080)
        else $error("page run too long");
    AST_ALIGN: assert property ($rose(fl_prog_we) |-> fl_prog_addr[6:0] == 7'h00)
        else $error("page start not aligned");
    AST_STEP: assert property (fl_prog_we && $past(fl_prog_we) |-> fl_prog_addr == $past(fl_prog_addr) + 15'h0001)
        else $error("page address not stepping");
    AST_EXCL: assert property (!(fl_prog_we && fl_erase_en))
        else $error("program and erase together");
    AST_ONEHOT: assert property (fl_erase_en |-> $onehot(fl_erase_blk))
        else $error("erase not one block");
    AST_BASE: assert property (fl_erase_en |-> fl_erase_base == exp_base)
        else $error("erase base wrong");
    AST_RSVD: assert property (avs_read && !avs_waitrequest && avs_address == 10'h000 |-> !avs_readdata[7])
        else $error("reserved bit read high");
    AST_ERASE_SETUP: assert property (fl_erase_en |-> fl_erase_setup)
        else $error("erase without erase setup");
endmodule // fpec_chk
bind fpec_flash_ctrl fpec_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fl_prog_we(fl_prog_we), .fl_prog_addr(fl_prog_addr), .fl_prog_data(fl_prog_data),
    .fl_erase_en(fl_erase_en), .fl_erase_blk(fl_erase_blk), .fl_erase_base(fl_erase_base),
    .fl_erase_setup(fl_erase_setup), .fl_prog_setup(fl_prog_setup),
    .fl_erase_verify(fl_erase_verify), .fl_prog_verify(fl_prog_verify));

// [fpec_tb.sv]
/* self-checking bench for fpec_flash_ctrl over avalon-mm.
   assumes one wait cycle per access and registered flash outputs. */
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    reg         sys_clk, rst_n, avs_read, avs_write;
    reg  [9:0]  avs_address;
    reg  [31:0] avs_writedata, rd_v;
    reg  [3:0]  avs_byteenable;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, fl_prog_we, fl_erase_en;
    wire        fl_erase_setup, fl_prog_setup, fl_erase_verify, fl_prog_verify;
    wire [14:0] fl_prog_addr, fl_erase_base;
    wire [7:0]  fl_prog_data;
    wire [4:0]  fl_erase_blk;
    integer     n_mismatch, comparisons, i, k, n, nw, ne;
    fpec_flash_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fl_prog_we(fl_prog_we), .fl_prog_addr(fl_prog_addr), .fl_prog_data(fl_prog_data),
        .fl_erase_en(fl_erase_en), .fl_erase_blk(fl_erase_blk), .fl_erase_base(fl_erase_base),
        .fl_erase_setup(fl_erase_setup), .fl_prog_setup(fl_prog_setup),
        .fl_erase_verify(fl_erase_verify), .fl_prog_verify(fl_prog_verify));
    // ****************************************
    // clock, bus tasks and report
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task test_done;
        begin
            $display("counts mismatches=%0d compares=%0d", n_mismatch, comparisons);
            if (n_mismatch == 0 && comparisons > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // request held until waitrequest is sampled low, then released
    task bus(input rw, input [9:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge sys_clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_read <= !rw;
            avs_write <= rw;
            t = 0;
            @(posedge sys_clk);
            while (avs_waitrequest !== 1'b0 && t < 20) begin
                @(posedge sys_clk);
                t = t + 1;
            end
            if (avs_waitrequest !== 1'b0) begin
                n_mismatch++;
                test_done;
            end else begin
                rd_v = avs_readdata;
                avs_read <= 1'b0;
                avs_write <= 1'b0;
            end
        end
    endtask
    task wr(input [9:0] a, input [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rdc(input [9:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0000_0000);
            `CHK(rd_v, e)
        end
    endtask
    // counts program and erase activity over a window
    task watch(input integer c);
        begin
            nw = 0;
            ne = 0;
            repeat (c) begin
                @(posedge sys_clk);
                if (fl_prog_we === 1'b1) nw++;
                if (fl_erase_en === 1'b1) ne++;
            end
        end
    endtask
    function [7:0] pb(input integer j);
        pb = 8'h11 + j[7:0] * 8'h03;
    endfunction
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        begin
            `CHK({fl_prog_we, fl_erase_en, fl_erase_setup, fl_prog_setup}, 4'h0)
            wr(10'h000, 32'h0000_0040);
            wr(10'h00C, 32'h0000_0080);
            rdc(10'h00C, 32'h0000_0080);
            rdc(10'h000, 32'h0000_0000);
            rdc(10'h008, 32'h0000_0000);
            rdc(10'h3F0, 32'h0000_0000);
            $display("test reset done");
        end
    endtask
    task t_lock;
        begin
            wr(10'h000, 32'h0000_00BF);
            rdc(10'h000, 32'h0000_0000);
            wr(10'h008, 32'h0000_0001);
            rdc(10'h008, 32'h0000_0000);
            `CHK({fl_erase_setup, fl_prog_setup, fl_erase_verify, fl_prog_verify}, 4'h0)
            wr(10'h000, 32'h0000_007F);
            rdc(10'h000, 32'h0000_0040);
            $display("test lock done");
        end
    endtask
    task t_bits;
        begin
            for (k = 0; k < 16; k++) begin
                wr(10'h000, 32'h0000_00C0 | (k << 2));
                repeat (2) @(posedge sys_clk);
                `CHK({fl_erase_setup, fl_prog_setup, fl_erase_verify, fl_prog_verify}, k[3:0])
                rdc(10'h000, 32'h0000_0040 | (k << 2));
            end
            wr(10'h000, 32'h0000_003C);
            repeat (2) @(posedge sys_clk);
            `CHK({fl_erase_setup, fl_prog_setup, fl_erase_verify, fl_prog_verify}, 4'h0)
            $display("test mode bits done");
        end
    endtask
    task t_erase;
        begin
            wr(10'h000, 32'h0000_0040);
            wr(10'h000, 32'h0000_0060);
            for (i = 0; i < 5; i++) begin
                wr(10'h008, 32'h0000_0001 << i);
                wr(10'h000, 32'h0000_0062);
                repeat (2) @(posedge sys_clk);
                `CHK(fl_erase_en, 1'b1)
                `CHK(fl_erase_blk, 5'h01 << i)
                `CHK(fl_erase_base, (i == 4) ? 15'h1000 : 15'h0400 * i[2:0])
                wr(10'h000, 32'h0000_0060);
                repeat (2) @(posedge sys_clk);
                `CHK(fl_erase_en, 1'b0)
            end
            wr(10'h000, 32'h0000_0042);
            watch(4);
            `CHK(ne, 0)
            wr(10'h000, 32'h0000_0040);
            wr(10'h008, 32'h0000_0003);
            rdc(10'h008, 32'h0000_0000);
            wr(10'h000, 32'h0000_0062);
            watch(4);
            `CHK(ne, 0)
            $display("test erase done");
        end
    endtask
    task t_prog;
        begin
            for (k = 0; k < 32; k++)
                wr(10'h200 + 10'(k * 4), {pb(4 * k + 3), pb(4 * k + 2), pb(4 * k + 1), pb(4 * k)});
            // page start on a 128-byte boundary
            wr(10'h010, 32'h0000_0480);
            rdc(10'h010, 32'h0000_0480);
            wr(10'h000, 32'h0000_0040);
            wr(10'h000, 32'h0000_0050);
            wr(10'h000, 32'h0000_0051);
            n = 0;
            for (i = 0; i < 200; i++) begin
                @(posedge sys_clk);
                if (fl_prog_we === 1'b1) begin
                    `CHK(fl_prog_addr, 15'h0480 + n[14:0])
                    `CHK(fl_prog_data, pb(n))
                    n++;
                end
            end
            `CHK(n, 128)
            wr(10'h000, 32'h0000_0050);
            wr(10'h000, 32'h0000_0041);
            watch(20);
            `CHK(nw, 0)
            wr(10'h008, 32'h0000_0001);
            wr(10'h000, 32'h0000_0073);
            watch(20);
            `CHK(nw + ne, 0)
            bus(1'b0, 10'h004, 32'h0000_0000);
            `CHK(rd_v[7], 1'b1)
            wr(10'h000, 32'h0000_0000);
            $display("test program done");
        end
    endtask
    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 10'h000;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        n_mismatch = 0;
        comparisons = 0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset;
        t_lock;
        t_bits;
        t_erase;
        t_prog;
        test_done;
    end
endmodule // tb_top
